// ### rtl/cpd_ctrl.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module cpd_ctrl
    import cpd_pkg::*;
#(
    parameter int LOCK_CYCLES = CPD_LOCK_CYCLES,
    parameter int HALT_LATENCY = CPD_HALT_LATENCY
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire cpd_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic multiply_select,
    input wire logic [2:0] freq_range_select,
    input wire logic irq_any,
    input wire logic irq_enabled,
    output cpd_clk_en_t clk_en,
    output logic pll_locked,
    output logic cpu_halt_state,
    output logic pll_output_stop_state,
    output logic pll_input_stop_state
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int LW = (LOCK_CYCLES > 1) ? $clog2(LOCK_CYCLES + 1) : 1;
    localparam int HW = $clog2(HALT_LATENCY + 1);

    if (LOCK_CYCLES < 1)
    begin : g_bad_lock
        $error("lock wait must be at least one cycle");
    end
    if (HALT_LATENCY < 1 || HALT_LATENCY > 255)
    begin : g_bad_halt
        $error("halt latency out of range");
    end

    // Bypass phase counter is only two bits wide
    if (CPD_BYPASS_DIV != 4)
    begin : g_bad_div
        $error("bypass divide must be four");
    end

    // Field code to legal mode check, used on write and on status
    function automatic logic powerdown_field_legal(input logic [5:0] code);
        powerdown_field_legal = (code == CPD_POWERDOWN_FIELD_NONE) || (code == CPD_POWERDOWN_FIELD_HALT_ENABLED) ||
            (code == CPD_POWERDOWN_FIELD_HALT_ANY) || (code == CPD_POWERDOWN_FIELD_OUT_STOP) ||
            (code == CPD_POWERDOWN_FIELD_IN_STOP);
    endfunction : powerdown_field_legal

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic mult_x4;
    logic [2:0] range_sel;

    // Board straps come from outside the clock domain
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end
        else
        begin
            pin_meta <= {multiply_select, freq_range_select};
            pin_sync <= pin_meta;
        end
    end

    assign mult_x4 = pin_sync[3];
    assign range_sel = pin_sync[2:0];

    // Range codes outside the three defined ones are flagged
    wire range_bad = (range_sel != CPD_RANGE_LOW) && (range_sel != CPD_RANGE_MID) &&
        (range_sel != CPD_RANGE_HIGH);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [5:0] powerdown_field;
    logic powerdown_field_bad;
    cpd_pd_state_t pd_state;
    cpd_pd_state_t next_pd_state;

    wire csr_hit = (bus_req.addr == CPD_CSR_OFFSET);
    wire status_hit = (bus_req.addr == CPD_STATUS_OFFSET);
    wire csr_wr = bus_req.wr && csr_hit;
    wire [5:0] wr_code = bus_req.wdata[CPD_POWERDOWN_FIELD_MSB:CPD_POWERDOWN_FIELD_LSB];

    // Other CPU_CONTROL_STATUS_POWERDOWN bits are not held by this block and read zero
    logic [31:0] csr_view;
    always_comb
    begin
        csr_view = 32'h0000_0000;
        csr_view[CPD_POWERDOWN_FIELD_MSB:CPD_POWERDOWN_FIELD_LSB] = powerdown_field;
    end

    // Status word placed by the package bit positions; unused bits read zero
    logic [31:0] status_view;
    always_comb
    begin
        status_view = 32'h0000_0000;
        status_view[CPD_ST_LOCKED] = pll_locked;
        status_view[CPD_ST_MULT] = mult_x4;
        status_view[CPD_ST_RANGE_LSB +: 3] = range_sel;
        status_view[CPD_ST_RANGE_BAD] = range_bad;
        status_view[CPD_ST_POWERDOWN_FIELD_BAD] = powerdown_field_bad;
        status_view[CPD_ST_HALTED] = cpu_halt_state;
        status_view[CPD_ST_OUT_STOP] = pll_output_stop_state;
        status_view[CPD_ST_IN_STOP] = pll_input_stop_state;
    end

    wire [31:0] next_rdata = !bus_req.rd ? 32'h0000_0000 :
        csr_hit ? csr_view :
        status_hit ? status_view : 32'h0000_0000;

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            rdata <= CPD_RESET_VALUE;
        else
            rdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // Power-down field
    // ------------------------------------------------------------
    logic wake;
    logic [HW-1:0] enter_cnt;

    // Writes land only in CPD_RUN; a write in the same cycle as a wake clear is dropped
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            powerdown_field <= CPD_RESET_VALUE[CPD_POWERDOWN_FIELD_MSB:CPD_POWERDOWN_FIELD_LSB];
            powerdown_field_bad <= 1'b0;
        end
        else if (csr_wr && (pd_state == CPD_RUN))
        begin
            // Whole field replaced at once; bit 15 stored as written
            powerdown_field <= wr_code;
            powerdown_field_bad <= !powerdown_field_legal(wr_code);
        end
        else if (wake)
            powerdown_field <= CPD_POWERDOWN_FIELD_NONE;
    end

    // ------------------------------------------------------------
    // Power-down state machine
    // ------------------------------------------------------------
    wire enter_any = (powerdown_field == CPD_POWERDOWN_FIELD_HALT_ANY);
    wire enter_en = (powerdown_field == CPD_POWERDOWN_FIELD_HALT_ENABLED);
    wire enter_go = (enter_cnt == HW'(1));

    // Any-interrupt mode also takes enabled interrupts
    assign wake = (pd_state == CPD_HALT) &&
        ((enter_any && (irq_any || irq_enabled)) || (enter_en && irq_enabled));

    always_comb
    begin
        next_pd_state = pd_state;
        unique case (pd_state)
            CPD_RUN:
                if (csr_wr && wr_code != CPD_POWERDOWN_FIELD_NONE && powerdown_field_legal(wr_code))
                    next_pd_state = CPD_ENTER;
            CPD_ENTER:
                if (enter_go)
                begin
                    if (powerdown_field == CPD_POWERDOWN_FIELD_OUT_STOP)
                        next_pd_state = CPD_OUT_STOP;
                    else if (powerdown_field == CPD_POWERDOWN_FIELD_IN_STOP)
                        next_pd_state = CPD_IN_STOP;
                    else
                        next_pd_state = CPD_HALT;
                end
            CPD_HALT:
                if (wake)
                    next_pd_state = CPD_RUN;
            // No exit but reset; registers keep their contents
            CPD_OUT_STOP:
                next_pd_state = CPD_OUT_STOP;
            CPD_IN_STOP:
                next_pd_state = CPD_IN_STOP;
            default:
                next_pd_state = CPD_RUN;
        endcase
    end

    // Entry delay: counted from the cycle after the write
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pd_state <= CPD_RUN;
            enter_cnt <= '0;
        end
        else
        begin
            pd_state <= next_pd_state;
            if (pd_state == CPD_RUN)
                enter_cnt <= HW'(HALT_LATENCY);
            else if (pd_state == CPD_ENTER)
                enter_cnt <= enter_cnt - HW'(1);
        end
    end

    // State flags for the rest of the chip
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cpu_halt_state <= 1'b0;
            pll_output_stop_state <= 1'b0;
            pll_input_stop_state <= 1'b0;
        end
        else
        begin
            cpu_halt_state <= (next_pd_state == CPD_HALT);
            pll_output_stop_state <= (next_pd_state == CPD_OUT_STOP);
            pll_input_stop_state <= (next_pd_state == CPD_IN_STOP);
        end
    end

    // ------------------------------------------------------------
    // PLL lock wait
    // ------------------------------------------------------------
    logic [LW-1:0] lock_cnt;
    logic mult_seen;

    // Multiplier change restarts the PLL; reset restarts it too
    wire pll_restart = (mult_x4 != mult_seen);

    // Wait uses the worst-case lock time, not the typical one
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            lock_cnt <= LW'(LOCK_CYCLES);
            mult_seen <= 1'b0;
            pll_locked <= 1'b0;
        end
        else
        begin
            mult_seen <= mult_x4;
            if (pll_restart)
            begin
                lock_cnt <= LW'(LOCK_CYCLES);
                pll_locked <= 1'b0;
            end
            else if (lock_cnt != '0)
                lock_cnt <= lock_cnt - LW'(1);
            else
                pll_locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------
    logic [1:0] ref_phase;
    logic half_phase;

    // ref_clk stands for the multiplied rate; bypass ticks one in four
    wire base_tick = mult_x4 ? 1'b1 : (ref_phase == 2'(CPD_BYPASS_DIV - 1));

    // Bypass needs no lock; times four waits for lock
    wire clk_ok = (!mult_x4 || pll_locked) && (next_pd_state != CPD_OUT_STOP) &&
        (next_pd_state != CPD_IN_STOP);

    wire core_tick = base_tick && clk_ok;
    wire cpu_tick = core_tick && (next_pd_state != CPD_HALT);

    // Half rate follows the core clock so it survives CPU halt
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ref_phase <= 2'h0;
            half_phase <= 1'b0;
            clk_en <= '0;
        end
        else
        begin
            ref_phase <= ref_phase + 2'h1;
            if (core_tick)
                half_phase <= !half_phase;
            clk_en.cpu_en <= cpu_tick;
            clk_en.core_en <= core_tick;
            clk_en.half_en <= core_tick && half_phase;
        end
    end

endmodule : cpd_ctrl

`default_nettype wire

// ### rtl/cpd_pkg.sv
package cpd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CPD_CSR_OFFSET = 8'h00;
    localparam logic [7:0] CPD_STATUS_OFFSET = 8'h04;
    localparam logic [31:0] CPD_RESET_VALUE = 32'h0000_0000;
    localparam int CPD_POWERDOWN_FIELD_LSB = 10;
    localparam int CPD_POWERDOWN_FIELD_MSB = 15;

    // Power-down field codes
    localparam logic [5:0] CPD_POWERDOWN_FIELD_NONE = 6'h00;
    localparam logic [5:0] CPD_POWERDOWN_FIELD_HALT_ENABLED = 6'h09;
    localparam logic [5:0] CPD_POWERDOWN_FIELD_HALT_ANY = 6'h11;
    localparam logic [5:0] CPD_POWERDOWN_FIELD_OUT_STOP = 6'h1A;
    localparam logic [5:0] CPD_POWERDOWN_FIELD_IN_STOP = 6'h1C;

    // Range select codes
    localparam logic [2:0] CPD_RANGE_LOW = 3'h0;
    localparam logic [2:0] CPD_RANGE_MID = 3'h1;
    localparam logic [2:0] CPD_RANGE_HIGH = 3'h2;

    // Status register bit positions
    localparam int CPD_ST_LOCKED = 0;
    localparam int CPD_ST_MULT = 1;
    localparam int CPD_ST_RANGE_LSB = 2;
    localparam int CPD_ST_RANGE_BAD = 5;
    localparam int CPD_ST_POWERDOWN_FIELD_BAD = 6;
    localparam int CPD_ST_HALTED = 8;
    localparam int CPD_ST_OUT_STOP = 9;
    localparam int CPD_ST_IN_STOP = 10;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CPD_CLK_PERIOD_NS = 10;
    localparam int CPD_LOCK_TYP_NS = 75000;
    localparam int CPD_LOCK_EXTRA_PCT = 150;
    // Longest lock: typical plus the extra share, rounded up
    localparam int CPD_LOCK_CYCLES =
        (CPD_LOCK_TYP_NS * (100 + CPD_LOCK_EXTRA_PCT) + 100 * CPD_CLK_PERIOD_NS - 1)
        / (100 * CPD_CLK_PERIOD_NS);
    localparam int CPD_HALT_LATENCY = 8;
    localparam int CPD_BYPASS_DIV = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cpd_bus_req_t;

    typedef struct packed {
        logic cpu_en;
        logic half_en;
        logic core_en;
    } cpd_clk_en_t;

    typedef enum logic [2:0] {
        CPD_RUN,
        CPD_ENTER,
        CPD_HALT,
        CPD_OUT_STOP,
        CPD_IN_STOP
    } cpd_pd_state_t;

endpackage : cpd_pkg

// ### verif/cpd_board.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Board strapping for the clock pins
// ------------------------------------------------------------
module cpd_board (
    input wire logic want_x4,
    input wire logic [7:0] want_mhz,
    input wire logic [3:0] force_code,
    output logic multiply_select,
    output logic [2:0] freq_range_select
);
    // Lowest range that holds the wanted rate; overlaps favour low code
    wire logic [2:0] lowest = (want_mhz <= 8'h8C) ? 3'h0 : 3'h1;
    // Straps are static levels; the override reaches reserved codes
    assign multiply_select = want_x4;
    assign freq_range_select = force_code[3] ? force_code[2:0] : lowest;
endmodule : cpd_board

`default_nettype wire

// ### verif/cpd_chk.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module cpd_chk
    import cpd_pkg::*;
#(
    parameter int LOCK_CYCLES = CPD_LOCK_CYCLES,
    parameter int HALT_LATENCY = CPD_HALT_LATENCY
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire cpd_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic multiply_select,
    input wire logic [2:0] freq_range_select,
    input wire logic irq_any,
    input wire logic irq_enabled,
    input wire cpd_clk_en_t clk_en,
    input wire logic pll_locked,
    input wire logic cpu_halt_state,
    input wire logic pll_output_stop_state,
    input wire logic pll_input_stop_state
);
    logic [15:0] since_rst;
    logic [3:0] gap;
    wire logic stop_any = pll_output_stop_state | pll_input_stop_state;
    wire logic [5:0] wcode = bus_req.wdata[15:10];
    // Halt request seen while running; writes elsewhere are refused
    wire logic halt_wr = bus_req.wr && bus_req.addr == CPD_CSR_OFFSET && !cpu_halt_state
        && !stop_any && (wcode == CPD_POWERDOWN_FIELD_HALT_ENABLED || wcode == CPD_POWERDOWN_FIELD_HALT_ANY);

    // Saturating counts: time since reset, cycles since last core tick
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            since_rst <= '0;
            gap <= '0;
        end
        else
        begin
            since_rst <= (since_rst == 16'hFFFF) ? since_rst : since_rst + 16'h0001;
            gap <= clk_en.core_en ? 4'h0 : ((gap == 4'hF) ? gap : gap + 4'h1);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    AST_LOCK_TIME: assert property ($rose(pll_locked) |-> since_rst >= LOCK_CYCLES)
        else $error("lock reported before the worst-case wait");
    AST_HALT_LAT: assert property ($rose(cpu_halt_state) |-> $past(halt_wr, HALT_LATENCY + 1))
        else $error("halt began at the wrong distance from its write");
    AST_WAKE: assert property (cpu_halt_state && irq_enabled |=> !cpu_halt_state)
        else $error("enabled interrupt did not end the halt");
    AST_HALT_CPU: assert property (cpu_halt_state |-> !clk_en.cpu_en)
        else $error("cpu tick during halt");
    AST_CORE_RUNS: assert property (cpu_halt_state && $past(pll_locked, 6) |-> gap < 4'h5)
        else $error("interrupt clock stalled during halt");
    AST_HALF_ALT: assert property (clk_en.core_en && $past(clk_en.core_en)
        |-> clk_en.half_en != $past(clk_en.half_en))
        else $error("half-rate tick did not alternate");
    AST_STOP_HOLD: assert property (stop_any
        |=> $stable({pll_output_stop_state, pll_input_stop_state}))
        else $error("stop state changed without reset");
    AST_STOP_GATE: assert property (stop_any |=> clk_en == 3'h0)
        else $error("clock tick in a stop state");
endmodule : cpd_chk

bind cpd_ctrl cpd_chk #(.LOCK_CYCLES(LOCK_CYCLES), .HALT_LATENCY(HALT_LATENCY)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .multiply_select(multiply_select), .freq_range_select(freq_range_select),
    .irq_any(irq_any), .irq_enabled(irq_enabled), .clk_en(clk_en), .pll_locked(pll_locked),
    .cpu_halt_state(cpu_halt_state), .pll_output_stop_state(pll_output_stop_state),
    .pll_input_stop_state(pll_input_stop_state)
);

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import cpd_pkg::*;
    localparam int LOCK = 20;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    cpd_bus_req_t bus_req = '0;
    logic [31:0] rdata;
    logic want_x4 = 1'b1;
    logic [7:0] want_mhz = 8'h85;
    logic [3:0] force_code = 4'h0;
    logic irq_any = 1'b0;
    logic irq_enabled = 1'b0;
    logic multiply_select;
    logic [2:0] freq_range_select;
    cpd_clk_en_t clk_en;
    logic pll_locked;
    logic cpu_halt_state;
    logic pll_output_stop_state;
    logic pll_input_stop_state;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    int nc;
    int nh;
    int np;
    logic [5:0] code;

    // ------------------------------------------------------------
    // Clock, board and design
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    cpd_board board (.want_x4(want_x4), .want_mhz(want_mhz), .force_code(force_code),
        .multiply_select(multiply_select), .freq_range_select(freq_range_select));
    cpd_ctrl #(.LOCK_CYCLES(LOCK)) DUT (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
        .rdata(rdata), .multiply_select(multiply_select), .freq_range_select(freq_range_select),
        .irq_any(irq_any), .irq_enabled(irq_enabled), .clk_en(clk_en), .pll_locked(pll_locked),
        .cpu_halt_state(cpu_halt_state), .pll_output_stop_state(pll_output_stop_state),
        .pll_input_stop_state(pll_input_stop_state));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    // Count core, half and cpu ticks over c cycles
    task ticks(input int c);
        nc = 0;
        nh = 0;
        np = 0;
        repeat (c)
        begin
            @(posedge ref_clk);
            #1;
            nc += int'(clk_en.core_en);
            nh += int'(clk_en.half_en);
            np += int'(clk_en.cpu_en);
        end
    endtask : ticks
    // Bounded wait for any power-down state, counting edges
    task wait_state();
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!(cpu_halt_state | pll_output_stop_state | pll_input_stop_state) && n < 40);
    endtask : wait_state
    task pulse(input logic en);
        @(posedge ref_clk);
        irq_enabled <= en;
        irq_any <= 1'b1;
        @(posedge ref_clk);
        irq_enabled <= 1'b0;
        irq_any <= 1'b0;
        #1;
    endtask : pulse
    task do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask : do_reset
    task print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Hang guard, far above the planned run
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset();
        n = 0;
        while (!pll_locked && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(32'(n >= LOCK && n <= LOCK + 4), 32'h1);
        rd(CPD_CSR_OFFSET, 32'h0000_0000);
        $display("test reset done");
        for (int c = 0; c < 8; c++)
        begin
            force_code <= {1'b1, 3'(c)};
            repeat (4) @(posedge ref_clk);
            rd(CPD_STATUS_OFFSET, 32'(3 + c * 4 + (c > 2) * 32));
        end
        force_code <= 4'h0;
        repeat (4) @(posedge ref_clk);
        rd(CPD_STATUS_OFFSET, 32'h0000_0003);
        want_mhz <= 8'hA7;
        repeat (4) @(posedge ref_clk);
        rd(CPD_STATUS_OFFSET, 32'h0000_0007);
        $display("test range done");
        wr(CPD_CSR_OFFSET, 32'h0000_7C00);
        rd(CPD_CSR_OFFSET, 32'h0000_7C00);
        rd(CPD_STATUS_OFFSET, 32'h0000_0047);
        wr(8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        wr(CPD_CSR_OFFSET, 32'h0000_0000);
        rd(CPD_CSR_OFFSET, 32'h0000_0000);
        $display("test field done");
        for (int i = 0; i < 2; i++)
        begin
            code = i ? CPD_POWERDOWN_FIELD_HALT_ANY : CPD_POWERDOWN_FIELD_HALT_ENABLED;
            wr(CPD_CSR_OFFSET, {16'h0000, code, 10'h000});
            wait_state();
            chk(32'(n), 32'(CPD_HALT_LATENCY));
            ticks(8);
            chk({8'h00, 8'(nc), 8'(nh), 8'(np)}, 32'h0008_0400);
            if (i == 0)
                pulse(1'b0);
            chk(32'(cpu_halt_state), 32'h1);
            pulse(i == 0);
            chk(32'(cpu_halt_state), 32'h0);
            rd(CPD_CSR_OFFSET, 32'h0000_0000);
        end
        $display("test halt done");
        want_x4 <= 1'b0;
        repeat (6) @(posedge ref_clk);
        ticks(16);
        chk({8'h00, 8'(nc), 8'(nh), 8'(np)}, 32'h0004_0204);
        $display("test bypass done");
        for (int i = 0; i < 2; i++)
        begin
            code = i ? CPD_POWERDOWN_FIELD_IN_STOP : CPD_POWERDOWN_FIELD_OUT_STOP;
            wr(CPD_CSR_OFFSET, {16'h0000, code, 10'h000});
            wait_state();
            chk(32'({pll_input_stop_state, pll_output_stop_state}), 32'(i + 1));
            wr(CPD_CSR_OFFSET, 32'h0000_0000);
            pulse(1'b1);
            ticks(8);
            chk(32'(nc + nh + np), 32'h0);
            rd(CPD_CSR_OFFSET, {16'h0000, code, 10'h000});
            do_reset();
            @(posedge ref_clk);
            #1;
            chk(32'({pll_input_stop_state, pll_output_stop_state}), 32'h0);
            rd(CPD_CSR_OFFSET, 32'h0000_0000);
        end
        $display("test stop done");
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
